// file: verilog/asm_regs.v
// Status and mode register bank of a six-channel converter.
//
// Contract
// - Status bit 15 follows interface lock and is 0 after reset.
// - Status bit 14 is set on every resynchronisation and is 0 after reset.
// - Status bit 13 shows the register-map checksum changed, 0 after reset.
// - Status bit 12 is set on an input frame checksum error, 0 after reset.
// - Status bit 11 shows the checksum type, 0 for CCITT, 1 for ANSI.
// - Status bit 10 is 1 after any reset until cleared.
// - Status bits 9:8 show the word length, 01 after reset.
// - Status bits 7:6 always read 00.
// - Status bits 5:0 show new data per channel, 0 after reset.
// - Mode register at 02h resets to 0510h with the listed fields.
// - Ready source picks lagging, OR, or leading enabled channel.
// - Mode bit 4 enables the interface timeout and resets to 1.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`include "asm_defines.vh"
module asm_regs #(
  parameter N_CH = 6
) (
  input  wire                   clk,
  input  wire                   sys_rst,
  input  wire [`ASM_ADDR_W-1:0] reg_addr,
  input  wire [15:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [15:0]            reg_rdata,
  input  wire                   lock_in,
  input  wire                   resync_ev,
  input  wire                   map_crc_changed_ev,
  input  wire                   rx_crc_err_ev,
  input  wire [N_CH-1:0]        ch_data_ev,
  input  wire [N_CH-1:0]        ch_data_read,
  input  wire [N_CH-1:0]        ch_enable,
  output reg                    map_crc_en,
  output reg                    rx_crc_en,
  output reg                    crc_type,
  output reg  [1:0]             sample_word_size,
  output reg                    timeout_en,
  output reg                    ready_pin_idle_float,
  output reg                    ready_pin_pulse_format,
  output reg                    ready_level,
  output reg                    irq
);
  reg  [15:0]            mode_word;
  reg                    mf_map_crc_en_r;
  reg                    mf_rx_crc_en_r;
  reg                    mf_crc_type_r;
  reg                    mf_rst_ack_r;
  reg  [1:0]             mf_word_size_r;
  reg                    mf_timeout_r;
  reg  [1:0]             mf_ready_sel_r;
  reg                    mf_float_r;
  reg                    mf_pulse_r;
  reg                    lock_s1_r;
  reg                    lock_s2_r;
  reg                    realign_r;
  reg                    map_chg_r;
  reg                    crc_err_r;
  reg                    rst_flag_r;
  reg  [N_CH-1:0]        new_r;
  reg  [`ASM_IRQ_W-1:0]  irq_stat_r;
  reg  [`ASM_IRQ_W-1:0]  irq_mask_r;
  reg  [15:0]            status_w;
  reg  [15:0]            rdata_nxt;
  wire                   ready_w;
  wire [`ASM_IRQ_W-1:0]  irq_ev;
  wire                   wr_mode;
  wire                   rd_irq;
  wire [1:0]             ready_pin_source_select;
  localparam [15:0]      MODE_RST = `ASM_MODE_RESET; // Mode word after reset.

  assign wr_mode = reg_wr && (reg_addr == `ASM_ADDR_MODE);
  assign rd_irq  = reg_rd && (reg_addr == `ASM_ADDR_IRQ_STAT);
  assign ready_pin_source_select = mf_ready_sel_r;

  // Lock is an asynchronous level, so it passes two flops first.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      lock_s1_r <= lock_in;
      lock_s2_r <= lock_s1_r;
    end
  end

  // Register map checksum enable field of the mode word.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_map_crc_en_r <= MODE_RST[`ASM_MODE_MAPCRC_EN];
    end else if (wr_mode) begin
      mf_map_crc_en_r <= reg_wdata[`ASM_MODE_MAPCRC_EN];
    end
  end

  // Input frame checksum enable field of the mode word.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_rx_crc_en_r <= MODE_RST[`ASM_MODE_RXCRC_EN];
    end else if (wr_mode) begin
      mf_rx_crc_en_r <= reg_wdata[`ASM_MODE_RXCRC_EN];
    end
  end

  // Checksum type field of the mode word.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_crc_type_r <= MODE_RST[`ASM_MODE_CRCTYPE];
    end else if (wr_mode) begin
      mf_crc_type_r <= reg_wdata[`ASM_MODE_CRCTYPE];
    end
  end

  // Reset acknowledge field, stored exactly as the host wrote it.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_rst_ack_r <= MODE_RST[`ASM_MODE_RSTACK];
    end else if (wr_mode) begin
      mf_rst_ack_r <= reg_wdata[`ASM_MODE_RSTACK];
    end
  end

  // Word length field of the mode word.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_word_size_r <= MODE_RST[`ASM_WLEN_HI:`ASM_WLEN_LO];
    end else if (wr_mode) begin
      mf_word_size_r <= reg_wdata[`ASM_WLEN_HI:`ASM_WLEN_LO];
    end
  end

  // Interface timeout enable, on by default.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_timeout_r <= MODE_RST[`ASM_MODE_TIMEOUT];
    end else if (wr_mode) begin
      mf_timeout_r <= reg_wdata[`ASM_MODE_TIMEOUT];
    end
  end

  // Ready source field that steers the ready selector.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_ready_sel_r <= MODE_RST[`ASM_SEL_HI:`ASM_SEL_LO];
    end else if (wr_mode) begin
      mf_ready_sel_r <= reg_wdata[`ASM_SEL_HI:`ASM_SEL_LO];
    end
  end

  // Ready pin idle float field of the mode word.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_float_r <= MODE_RST[`ASM_MODE_FLOAT];
    end else if (wr_mode) begin
      mf_float_r <= reg_wdata[`ASM_MODE_FLOAT];
    end
  end

  // Ready pin pulse format field of the mode word.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mf_pulse_r <= MODE_RST[`ASM_MODE_PULSE];
    end else if (wr_mode) begin
      mf_pulse_r <= reg_wdata[`ASM_MODE_PULSE];
    end
  end

  // Mode word as read back; reserved bits have no storage and read zero.
  always @* begin
    mode_word = `ASM_ZERO16;
    mode_word[`ASM_MODE_MAPCRC_EN]        = mf_map_crc_en_r;
    mode_word[`ASM_MODE_RXCRC_EN]         = mf_rx_crc_en_r;
    mode_word[`ASM_MODE_CRCTYPE]          = mf_crc_type_r;
    mode_word[`ASM_MODE_RSTACK]           = mf_rst_ack_r;
    mode_word[`ASM_WLEN_HI:`ASM_WLEN_LO]  = mf_word_size_r;
    mode_word[`ASM_MODE_TIMEOUT]          = mf_timeout_r;
    mode_word[`ASM_SEL_HI:`ASM_SEL_LO]    = mf_ready_sel_r;
    mode_word[`ASM_MODE_FLOAT]            = mf_float_r;
    mode_word[`ASM_MODE_PULSE]            = mf_pulse_r;
  end

  // Sticky event flags; only reset clears the event flags, and a zero acknowledge write clears the reset flag.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      realign_r  <= 1'b0;
      map_chg_r  <= 1'b0;
      crc_err_r  <= 1'b0;
      rst_flag_r <= MODE_RST[`ASM_MODE_RSTACK];
    end else begin
      if (resync_ev) begin
        realign_r <= 1'b1;
      end
      if (map_crc_changed_ev) begin
        map_chg_r <= 1'b1;
      end
      if (rx_crc_err_ev) begin
        crc_err_r <= 1'b1;
      end
      if (wr_mode && !reg_wdata[`ASM_MODE_RSTACK]) begin
        rst_flag_r <= 1'b0;
      end
    end
  end

  // Per-channel new-data flags, cleared when that channel's data is read.
  genvar gi;
  generate
    for (gi = 0; gi < N_CH; gi = gi + 1) begin : g_ch
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          new_r[gi] <= 1'b0;
        end else if (ch_data_ev[gi]) begin
          new_r[gi] <= 1'b1;
        end else if (ch_data_read[gi]) begin
          new_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Status word assembly.
  always @* begin
    status_w = `ASM_ZERO16;
    status_w[`ASM_STAT_LOCK]    = lock_s2_r;
    status_w[`ASM_STAT_RESYNC]  = realign_r;
    status_w[`ASM_STAT_MAPCRC]  = map_chg_r;
    status_w[`ASM_STAT_CRCERR]  = crc_err_r;
    status_w[`ASM_STAT_CRCTYPE] = mode_word[`ASM_MODE_CRCTYPE];
    status_w[`ASM_STAT_RSTFLAG] = rst_flag_r;
    status_w[`ASM_WLEN_HI:`ASM_WLEN_LO] = mode_word[`ASM_WLEN_HI:`ASM_WLEN_LO];
    status_w[N_CH-1:0] = new_r;
  end

  // Interrupt events: resync, map change, input error, any new data.
  assign irq_ev = {|ch_data_ev, rx_crc_err_ev, map_crc_changed_ev, resync_ev};

  // Interrupt status is sticky and cleared by its read; set wins.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= {`ASM_IRQ_W{1'b0}};
      irq_mask_r <= {`ASM_IRQ_W{1'b0}};
    end else begin
      irq_stat_r <= (rd_irq ? {`ASM_IRQ_W{1'b0}} : irq_stat_r) | irq_ev;
      if (reg_wr && (reg_addr == `ASM_ADDR_IRQ_MASK)) begin
        irq_mask_r <= reg_wdata[`ASM_IRQ_W-1:0];
      end
    end
  end

  // Read mux; status is read-only, so writes to it are ignored.
  always @* begin
    case (reg_addr)
      `ASM_ADDR_STATUS:   rdata_nxt = status_w;
      `ASM_ADDR_MODE:     rdata_nxt = mode_word;
      `ASM_ADDR_IRQ_MASK: rdata_nxt = {{(16-`ASM_IRQ_W){1'b0}}, irq_mask_r};
      `ASM_ADDR_IRQ_STAT: rdata_nxt = {{(16-`ASM_IRQ_W){1'b0}}, irq_stat_r};
      default:            rdata_nxt = `ASM_ZERO16;
    endcase
  end

  asm_ready_sel #(
    .N_CH (N_CH)
  ) u_ready (
    .ch_ready  (new_r),
    .ch_enable (ch_enable),
    .sel       (ready_pin_source_select),
    .ready     (ready_w)
  );

  // Read data stands for the one cycle after a read strobe and is zero otherwise.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `ASM_ZERO16;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : `ASM_ZERO16;
    end
  end

  // Map checksum enable output, one cycle behind its mode field.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      map_crc_en <= MODE_RST[`ASM_MODE_MAPCRC_EN];
    end else begin
      map_crc_en <= mf_map_crc_en_r;
    end
  end

  // Input checksum enable output, one cycle behind its mode field.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_crc_en <= MODE_RST[`ASM_MODE_RXCRC_EN];
    end else begin
      rx_crc_en <= mf_rx_crc_en_r;
    end
  end

  // Checksum type output, one cycle behind its mode field.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_type <= MODE_RST[`ASM_MODE_CRCTYPE];
    end else begin
      crc_type <= mf_crc_type_r;
    end
  end

  // Word length output, one cycle behind its mode field.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_word_size <= MODE_RST[`ASM_WLEN_HI:`ASM_WLEN_LO];
    end else begin
      sample_word_size <= mf_word_size_r;
    end
  end

  // Timeout enable output, one cycle behind its mode field.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_en <= MODE_RST[`ASM_MODE_TIMEOUT];
    end else begin
      timeout_en <= mf_timeout_r;
    end
  end

  // Ready pin idle float output, one cycle behind its mode field.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_pin_idle_float <= MODE_RST[`ASM_MODE_FLOAT];
    end else begin
      ready_pin_idle_float <= mf_float_r;
    end
  end

  // Ready pin pulse format output, one cycle behind its mode field.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_pin_pulse_format <= MODE_RST[`ASM_MODE_PULSE];
    end else begin
      ready_pin_pulse_format <= mf_pulse_r;
    end
  end

  // Ready level from the selected source, registered to keep the pin glitch free.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_level <= 1'b0;
    end else begin
      ready_level <= ready_w;
    end
  end

  // Level interrupt, high while any unmasked status bit is set.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

// file: verilog/asm_defines.vh
// Constants for the status and mode register bank.
`ifndef ASM_DEFINES_VH
`define ASM_DEFINES_VH
`define ASM_ADDR_W          6
`define ASM_ADDR_STATUS     6'h01
`define ASM_ADDR_MODE       6'h02
`define ASM_ADDR_IRQ_MASK   6'h04
`define ASM_ADDR_IRQ_STAT   6'h05
`define ASM_MODE_RESET      16'h0510
`define ASM_MODE_WMASK      16'h3f1f
`define ASM_STAT_LOCK       15
`define ASM_STAT_RESYNC     14
`define ASM_STAT_MAPCRC     13
`define ASM_STAT_CRCERR     12
`define ASM_STAT_CRCTYPE    11
`define ASM_STAT_RSTFLAG    10
`define ASM_WLEN_HI         9
`define ASM_WLEN_LO         8
`define ASM_MODE_MAPCRC_EN  13
`define ASM_MODE_RXCRC_EN   12
`define ASM_MODE_CRCTYPE    11
`define ASM_MODE_RSTACK     10
`define ASM_MODE_TIMEOUT    4
`define ASM_SEL_HI          3
`define ASM_SEL_LO          2
`define ASM_MODE_FLOAT      1
`define ASM_MODE_PULSE      0
`define ASM_SEL_LAG         2'h0
`define ASM_SEL_OR          2'h1
`define ASM_IRQ_W           4
`define ASM_IRQ_RESYNC      0
`define ASM_IRQ_MAPCRC      1
`define ASM_IRQ_CRCERR      2
`define ASM_IRQ_DATA        3
`define ASM_ZERO16          16'h0000
`endif

// file: verilog/asm_ready_sel.v
// Ready source selection over the per-channel new-data flags.
`timescale 1ns/10ps
`include "asm_defines.vh"
module asm_ready_sel #(
  parameter N_CH = 6
) (
  input  wire [N_CH-1:0] ch_ready,
  input  wire [N_CH-1:0] ch_enable,
  input  wire [1:0]      sel,
  output reg             ready
);
  wire [N_CH-1:0] act;
  assign act = ch_ready & ch_enable;
  // Lagging waits for every enabled channel, leading takes the first one.
  always @* begin
    if (ch_enable == {N_CH{1'b0}}) begin
      ready = 1'b0;
    end else if (sel == `ASM_SEL_LAG) begin
      ready = (act == ch_enable);
    end else begin
      ready = |act;
    end
  end
endmodule

// file: dv/asm_regs_props.sv
// Checker for the status and mode register bank.
`timescale 1ns/10ps
module asm_regs_props #(
  parameter N_CH = 6
) (
  input wire            clk,
  input wire            sys_rst,
  input wire [5:0]      reg_addr,
  input wire [15:0]     reg_wdata,
  input wire            reg_wr,
  input wire            reg_rd,
  input wire [15:0]     reg_rdata,
  input wire            lock_in,
  input wire            resync_ev,
  input wire [N_CH-1:0] ch_data_ev,
  input wire [N_CH-1:0] ch_data_read,
  input wire [N_CH-1:0] ch_enable,
  input wire            crc_type,
  input wire [1:0]      sample_word_size,
  input wire            timeout_en,
  input wire            ready_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Decoded status read and mode access strobes.
  wire st_rd = reg_rd && reg_addr == 6'h01;
  wire md_rd = reg_rd && reg_addr == 6'h02;
  wire md_wr = reg_wr && reg_addr == 6'h02;
  rsv_stat_a: assert property (st_rd |=> reg_rdata[7:6] == 2'h0)
    else $error("status reserved bits set");
  rsv_mode_a: assert property (md_rd |=> reg_rdata[15:14] == 2'h0 && reg_rdata[7:5] == 3'h0)
    else $error("mode reserved bits set");
  unmap_rd_a: assert property (reg_rd && reg_addr > 6'h05 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  mode_out_a: assert property (md_wr |-> ##2 timeout_en == $past(reg_wdata[4], 2))
    else $error("timeout enable not applied");
  size_out_a: assert property (md_wr |-> ##2 sample_word_size == $past(reg_wdata[9:8], 2))
    else $error("word size not applied");
  crc_out_a: assert property (md_wr |-> ##2 crc_type == $past(reg_wdata[11], 2))
    else $error("checksum type not applied");
  lock_low_a: assert property ((!lock_in)[*4] ##0 st_rd |=> !reg_rdata[15])
    else $error("lock shown while unlocked");
  ready_off_a: assert property ((ch_enable == {N_CH{1'b0}})[*3] |-> !ready_level)
    else $error("ready with no channel");
  resync_a: assert property (resync_ev ##2 st_rd |=> reg_rdata[14])
    else $error("resync flag missing");
  new_data_a: assert property (ch_data_ev[0] ##1 !ch_data_read[0] ##1 st_rd |=> reg_rdata[0])
    else $error("new data flag missing");
  cover property (md_wr);
  cover property (st_rd ##1 reg_rdata[14]);
  cover property (ready_level);
endmodule

// file: dv/asm_host.sv
// Host model driving the register access port.
`timescale 1ns/10ps
module asm_host (
  input  wire        clk,
  input  wire [15:0] reg_rdata,
  output reg  [5:0]  reg_addr,
  output reg  [15:0] reg_wdata,
  output reg         reg_wr,
  output reg         reg_rd
);
  // Idle bus from time zero.
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 24'h0;
  end
  // One write cycle; released data is inverted so stale values never match.
  task wr(input [5:0] a, input [15:0] dt);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= dt;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~dt;
    end
  endtask
  // One read cycle; data is taken in the cycle after the strobe.
  task rd(input [5:0] a, output [15:0] dt);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 dt = reg_rdata;
    end
  endtask
endmodule

// file: dv/asm_regs_tb_top.sv
// Testbench top for the status and mode register bank.
`timescale 1ns/10ps
module asm_regs_tb_top;
  reg         clk, sys_rst, lock_in, resync_ev, map_crc_changed_ev, rx_crc_err_ev;
  reg  [5:0]  ch_data_ev, ch_data_read, ch_enable;
  reg  [15:0] d;
  wire [5:0]  reg_addr;
  wire [15:0] reg_wdata, reg_rdata;
  wire [1:0]  sample_word_size;
  wire        reg_wr, reg_rd, map_crc_en, rx_crc_en, crc_type, timeout_en, irq;
  wire        ready_pin_idle_float, ready_pin_pulse_format, ready_level;
  integer     fails, total_checks, i;
  asm_regs asm_regs_i (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .lock_in                (lock_in),
    .resync_ev              (resync_ev),
    .map_crc_changed_ev     (map_crc_changed_ev),
    .rx_crc_err_ev          (rx_crc_err_ev),
    .ch_data_ev             (ch_data_ev),
    .ch_data_read           (ch_data_read),
    .ch_enable              (ch_enable),
    .map_crc_en             (map_crc_en),
    .rx_crc_en              (rx_crc_en),
    .crc_type               (crc_type),
    .sample_word_size       (sample_word_size),
    .timeout_en             (timeout_en),
    .ready_pin_idle_float   (ready_pin_idle_float),
    .ready_pin_pulse_format (ready_pin_pulse_format),
    .ready_level            (ready_level),
    .irq                    (irq)
  );
  asm_host asm_host_i (
    .clk       (clk),
    .reg_rdata (reg_rdata),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd)
  );
  // Compare helpers count every check and report mismatches.
  task cmp16(input [15:0] g, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cmp1(input g, input e);
    cmp16({15'h0, g}, {15'h0, e});
  endtask
  task rdc(input [5:0] a, input [15:0] e);
    begin
      asm_host_i.rd(a, d);
      cmp16(d, e);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always #2 clk = ~clk;
  // Watchdog far beyond the expected run length.
  initial begin
    #20000;
    fails = fails + 1;
    stop_test;
  end
  // Test sequence.
  initial begin
    {clk, sys_rst, lock_in, resync_ev, map_crc_changed_ev, rx_crc_err_ev} = 6'h10;
    {ch_data_ev, ch_data_read, ch_enable} = 18'h0;
    {fails, total_checks} = 64'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(6'h01, 16'h0500);
    rdc(6'h02, 16'h0510);
    $display("test 1 done");
    asm_host_i.wr(6'h02, 16'hffff);
    rdc(6'h02, 16'h3f1f);
    asm_host_i.wr(6'h01, 16'h0000);
    rdc(6'h01, 16'h0f00);
    cmp16({8'h00, map_crc_en, rx_crc_en, crc_type, sample_word_size, timeout_en,
           ready_pin_idle_float, ready_pin_pulse_format}, 16'h00ff);
    $display("test 2 done");
    // Word sizes; a zero acknowledge also clears the reset flag.
    for (i = 0; i < 4; i = i + 1) begin
      asm_host_i.wr(6'h02, {6'h00, i[1:0], 8'h00});
      rdc(6'h01, {6'h00, i[1:0], 8'h00});
      cmp16({14'h0, sample_word_size}, {14'h0, i[1:0]});
    end
    $display("test 3 done");
    @(posedge clk);
    lock_in <= 1'b1;
    ch_enable <= 6'h3f;
    repeat (4) @(posedge clk);
    {resync_ev, map_crc_changed_ev, rx_crc_err_ev, ch_data_ev} <= 9'h1ff;
    @(posedge clk);
    {resync_ev, map_crc_changed_ev, rx_crc_err_ev, ch_data_ev} <= 9'h000;
    rdc(6'h01, 16'hf33f);
    cmp1(ready_level, 1'b1);
    // Interrupt mask gates the output; a read of the interrupt status clears it.
    asm_host_i.wr(6'h04, 16'h000f);
    @(posedge clk);
    #1 cmp1(irq, 1'b1);
    asm_host_i.wr(6'h04, 16'h0000);
    @(posedge clk);
    #1 cmp1(irq, 1'b0);
    asm_host_i.wr(6'h04, 16'h000f);
    rdc(6'h05, 16'h000f);
    rdc(6'h05, 16'h0000);
    cmp1(irq, 1'b0);
    @(posedge clk);
    {ch_data_read, lock_in} <= 7'h7e;
    @(posedge clk);
    ch_data_read <= 6'h00;
    repeat (4) @(posedge clk);
    rdc(6'h01, 16'h7300);
    $display("test 4 done");
    @(posedge clk);
    ch_data_ev <= 6'h01;
    @(posedge clk);
    ch_data_ev <= 6'h00;
    for (i = 0; i < 4; i = i + 1) begin
      asm_host_i.wr(6'h02, {12'h030, i[1:0], 2'h0});
      repeat (3) @(posedge clk);
      #1 cmp1(ready_level, i != 0);
    end
    rdc(6'h3f, 16'h0000);
    $display("test 5 done");
    // A second reset restores the defaults, clears the sticky event flags and sets the reset flag.
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(6'h01, 16'h0500);
    cmp16({14'h0, sample_word_size}, 16'h0001);
    cmp1(timeout_en, 1'b1);
    $display("test 6 done");
    stop_test;
  end
endmodule
bind asm_regs asm_regs_props #(
  .N_CH (N_CH)
) asm_regs_props_i (
  .clk              (clk),
  .sys_rst          (sys_rst),
  .reg_addr         (reg_addr),
  .reg_wdata        (reg_wdata),
  .reg_wr           (reg_wr),
  .reg_rd           (reg_rd),
  .reg_rdata        (reg_rdata),
  .lock_in          (lock_in),
  .resync_ev        (resync_ev),
  .ch_data_ev       (ch_data_ev),
  .ch_data_read     (ch_data_read),
  .ch_enable        (ch_enable),
  .crc_type         (crc_type),
  .sample_word_size (sample_word_size),
  .timeout_en       (timeout_en),
  .ready_level      (ready_level)
);
